//--- hdl/dma_chan_seq.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

module dma_chan_seq (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [7:0]             paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output dma_chan_pkg::mem_req_t      mem_req,
	input  wire logic                   mem_ack,
	input  wire logic [31:0]            mem_rdata,
	input  wire logic                   dreq,
	output logic                        hash_valid,
	output logic      [31:0]            hash_data,
	input  wire logic                   hash_ready,
	output logic      [2:0]             hash_fifo_level,
	output logic                        tc_irq,
	output logic                        null_link_irq
);

	typedef struct packed {
		dma_chan_pkg::state_t               fsm;
		dma_chan_pkg::ctrl_t                ctrl;
		dma_chan_pkg::stride_t              stride;
		dma_chan_pkg::desc_t                pri;
		dma_chan_pkg::desc_t                sec;
		logic                               tc_sts;
		logic                               null_sts;
		logic [1:0]                         mask;
		logic [31:0]                        cnt;
		logic [1:0]                         fidx;
		logic [31:0]                        data;
		logic [dma_chan_pkg::FIFO_DEPTH-1:0][31:0] fifo;
		logic [1:0]                         wp;
		logic [1:0]                         rp;
		logic [2:0]                         fcnt;
		logic                               hv;
		logic [31:0]                        hd;
		dma_chan_pkg::mem_req_t             mem;
		logic [31:0]                        prdata;
		logic                               pready;
		logic                               pslverr;
		logic                               tc_irq;
		logic                               nl_irq;
	} st_t;

	st_t         s_reg;
	st_t         s_next;
	logic        apb_wr;
	logic        apb_setup;
	logic        push;
	logic        pop;
	logic        ag_load;
	logic        ag_adv;
	logic [31:0] src_addr;
	logic [31:0] dst_addr;
	logic [31:0] bytes;
	logic [31:0] rd_word;
	logic        rd_ok;

	assign apb_wr    = psel && penable && s_reg.pready && pwrite;
	assign apb_setup = psel && !penable;
	assign ag_load   = s_reg.fsm == dma_chan_pkg::ST_LOAD;
	assign ag_adv    = s_reg.fsm == dma_chan_pkg::ST_STEP;
	assign bytes     = dma_chan_pkg::size_bytes(s_reg.ctrl.source_word_size);

	// ----------------------------------------------------------------
	// address generators
	// ----------------------------------------------------------------
	dma_addr_gen u_src_gen (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (ag_load),
		.base      (s_reg.pri[dma_chan_pkg::DESC_SRC]),
		.advance   (ag_adv),
		.hold      (s_reg.ctrl.source_hold_address),
		.stride_en (s_reg.ctrl.source_stride_enable),
		.size      (s_reg.ctrl.source_word_size),
		.step_mult (s_reg.stride.stride_step_multiple),
		.steps     (s_reg.stride.stride_steps_per_set),
		.addr      (src_addr)
	);

	dma_addr_gen u_dst_gen (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (ag_load),
		.base      (s_reg.pri[dma_chan_pkg::DESC_DST]),
		.advance   (ag_adv),
		.hold      (s_reg.ctrl.destination_hold_address),
		.stride_en (s_reg.ctrl.destination_stride_enable),
		.size      (s_reg.ctrl.destination_word_size),
		.step_mult (s_reg.stride.stride_step_multiple),
		.steps     (s_reg.stride.stride_steps_per_set),
		.addr      (dst_addr)
	);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0;
		rd_ok   = 1'b1;
		unique case (paddr)
			dma_chan_pkg::OFS_CTRL:         rd_word = s_reg.ctrl;
			dma_chan_pkg::OFS_STRIDE:       rd_word = s_reg.stride;
			dma_chan_pkg::OFS_PRI:          rd_word = s_reg.pri[0];
			dma_chan_pkg::OFS_PRI + 8'h04:  rd_word = s_reg.pri[1];
			dma_chan_pkg::OFS_PRI + 8'h08:  rd_word = s_reg.pri[2];
			dma_chan_pkg::OFS_PRI + 8'h0c:  rd_word = s_reg.pri[3];
			dma_chan_pkg::OFS_SEC:          rd_word = s_reg.sec[0];
			dma_chan_pkg::OFS_SEC + 8'h04:  rd_word = s_reg.sec[1];
			dma_chan_pkg::OFS_SEC + 8'h08:  rd_word = s_reg.sec[2];
			dma_chan_pkg::OFS_SEC + 8'h0c:  rd_word = s_reg.sec[3];
			dma_chan_pkg::OFS_STATUS: begin
				rd_word[dma_chan_pkg::STS_TC]      = s_reg.tc_sts;
				rd_word[dma_chan_pkg::STS_NULL]    = s_reg.null_sts;
				rd_word[dma_chan_pkg::STS_FIFO_NE] = s_reg.fcnt != 3'h0 || s_reg.hv;
				rd_word[dma_chan_pkg::STS_FIFO_LVL +: 3] = s_reg.fcnt;
				rd_word[dma_chan_pkg::STS_BUSY]    = s_reg.fsm != dma_chan_pkg::ST_IDLE;
			end
			dma_chan_pkg::OFS_MASK:         rd_word = {30'h0, s_reg.mask};
			dma_chan_pkg::OFS_IRQ: begin
				rd_word[dma_chan_pkg::STS_TC]   = s_reg.tc_irq;
				rd_word[dma_chan_pkg::STS_NULL] = s_reg.nl_irq;
			end
			default:                        rd_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next  = s_reg;
		push    = 1'b0;
		pop     = 1'b0;

		// apb slave: one wait-free access phase
		s_next.pready = apb_setup;
		if (apb_setup) begin
			s_next.prdata  = rd_word;
			s_next.pslverr = !rd_ok;
		end
		if (apb_wr && !s_reg.pslverr) begin
			unique case (paddr)
				dma_chan_pkg::OFS_CTRL: begin
					s_next.ctrl      = dma_chan_pkg::ctrl_t'(pwdata);
					s_next.ctrl.rsvd = '0;
				end
				dma_chan_pkg::OFS_STRIDE: begin
					s_next.stride      = dma_chan_pkg::stride_t'(pwdata);
					s_next.stride.rsvd = '0;
				end
				dma_chan_pkg::OFS_PRI:         s_next.pri[0] = pwdata;
				dma_chan_pkg::OFS_PRI + 8'h04: s_next.pri[1] = pwdata;
				dma_chan_pkg::OFS_PRI + 8'h08: s_next.pri[2] = pwdata;
				dma_chan_pkg::OFS_PRI + 8'h0c: s_next.pri[3] = pwdata;
				dma_chan_pkg::OFS_SEC:         s_next.sec[0] = pwdata;
				dma_chan_pkg::OFS_SEC + 8'h04: s_next.sec[1] = pwdata;
				dma_chan_pkg::OFS_SEC + 8'h08: s_next.sec[2] = pwdata;
				dma_chan_pkg::OFS_SEC + 8'h0c: s_next.sec[3] = pwdata;
				dma_chan_pkg::OFS_STATUS: begin
					// write one to clear; a same-cycle hardware set wins below
					if (pwdata[dma_chan_pkg::STS_TC])   s_next.tc_sts   = 1'b0;
					if (pwdata[dma_chan_pkg::STS_NULL]) s_next.null_sts = 1'b0;
				end
				dma_chan_pkg::OFS_MASK:        s_next.mask = pwdata[1:0];
				default: begin
				end
			endcase
		end

		unique case (s_reg.fsm)
			dma_chan_pkg::ST_IDLE: begin
				if (s_reg.ctrl.channel_enable) begin
					s_next.fidx = 2'h0;
					// linked start uses only the link word of the primary set
					s_next.fsm  = s_reg.ctrl.chain_enable ? dma_chan_pkg::ST_FETCH
					                                      : dma_chan_pkg::ST_LOAD;
				end
			end
			dma_chan_pkg::ST_FETCH: begin
				if (mem_ack) begin
					s_next.sec[s_reg.fidx] = mem_rdata;
					s_next.fidx            = s_reg.fidx + 2'h1;
					if (s_reg.fidx == dma_chan_pkg::DESC_LAST) begin
						s_next.pri = s_next.sec;
						if (mem_rdata == dma_chan_pkg::NULL_LINK) begin
							s_next.null_sts = 1'b1;
						end
						s_next.fsm = dma_chan_pkg::ST_LOAD;
					end
				end
			end
			dma_chan_pkg::ST_LOAD: begin
				s_next.cnt = 32'h0;
				s_next.fsm = (s_reg.pri[dma_chan_pkg::DESC_LEN] == 32'h0) ? dma_chan_pkg::ST_TERM
				                                                          : dma_chan_pkg::ST_WAIT;
			end
			dma_chan_pkg::ST_WAIT: begin
				if (!s_reg.ctrl.channel_enable) begin
					s_next.fsm = dma_chan_pkg::ST_IDLE;
				end else if (s_reg.ctrl.software_transfer_enable || dreq) begin
					s_next.fsm = dma_chan_pkg::ST_READ;
				end
			end
			dma_chan_pkg::ST_READ: begin
				if (mem_ack) begin
					s_next.data = mem_rdata;
					if (!s_reg.ctrl.null_destination_select) begin
						s_next.fsm = dma_chan_pkg::ST_WRITE;
					end else begin
						s_next.fsm = s_reg.ctrl.hash_feed_enable ? dma_chan_pkg::ST_HASH
						                                         : dma_chan_pkg::ST_STEP;
					end
				end
			end
			dma_chan_pkg::ST_WRITE: begin
				if (mem_ack) begin
					s_next.fsm = s_reg.ctrl.hash_feed_enable ? dma_chan_pkg::ST_HASH
					                                         : dma_chan_pkg::ST_STEP;
				end
			end
			dma_chan_pkg::ST_HASH: begin
				// stalls while the fifo is full
				if (s_reg.fcnt != dma_chan_pkg::FIFO_FULL) begin
					push       = 1'b1;
					s_next.fsm = dma_chan_pkg::ST_STEP;
				end
			end
			dma_chan_pkg::ST_STEP: begin
				s_next.cnt = s_reg.cnt + bytes;
				s_next.fsm = (s_reg.cnt + bytes >= s_reg.pri[dma_chan_pkg::DESC_LEN])
				             ? dma_chan_pkg::ST_TERM : dma_chan_pkg::ST_WAIT;
			end
			dma_chan_pkg::ST_TERM: begin
				if (s_reg.ctrl.chain_enable) begin
					if (s_reg.pri[dma_chan_pkg::DESC_LINK] == dma_chan_pkg::NULL_LINK) begin
						s_next.ctrl.double_buffer_enable = 1'b0;
						s_next.ctrl.channel_enable       = 1'b0;
						s_next.tc_sts                    = 1'b1;
						s_next.fsm                       = dma_chan_pkg::ST_IDLE;
					end else begin
						if (s_reg.ctrl.link_int_every) begin
							s_next.tc_sts = 1'b1;
						end
						s_next.fidx = 2'h0;
						s_next.fsm  = dma_chan_pkg::ST_FETCH;
					end
				end else begin
					s_next.tc_sts = 1'b1;
					if (s_reg.ctrl.double_buffer_enable) begin
						s_next.pri[2:0]                  = s_reg.sec[2:0];
						s_next.ctrl.double_buffer_enable = 1'b0;
						s_next.ctrl.channel_enable       = 1'b1;
						s_next.fsm                       = dma_chan_pkg::ST_LOAD;
					end else begin
						s_next.ctrl.channel_enable = 1'b0;
						s_next.fsm                 = dma_chan_pkg::ST_IDLE;
					end
				end
			end
		endcase

		// hash fifo drain runs whatever the channel does
		if (!s_reg.hv || hash_ready) begin
			if (s_reg.fcnt != 3'h0) begin
				pop       = 1'b1;
				s_next.hd = s_reg.fifo[s_reg.rp];
				s_next.hv = 1'b1;
				s_next.rp = s_reg.rp + 2'h1;
			end else begin
				s_next.hv = 1'b0;
			end
		end
		if (push) begin
			s_next.fifo[s_reg.wp] = s_reg.data;
			s_next.wp             = s_reg.wp + 2'h1;
		end
		s_next.fcnt = s_reg.fcnt + {2'h0, push} - {2'h0, pop};

		// memory request follows the state being entered
		s_next.mem.req   = 1'b0;
		s_next.mem.write = 1'b0;
		s_next.mem.size  = s_next.ctrl.source_word_size;
		s_next.mem.addr  = 32'h0;
		s_next.mem.wdata = s_next.data;
		unique case (s_next.fsm)
			dma_chan_pkg::ST_FETCH: begin
				s_next.mem.req  = 1'b1;
				s_next.mem.size = 2'h2;
				s_next.mem.addr = dma_chan_pkg::fetch_addr(s_next.pri[dma_chan_pkg::DESC_LINK],
				                                           s_next.fidx);
			end
			dma_chan_pkg::ST_READ: begin
				s_next.mem.req  = 1'b1;
				s_next.mem.addr = src_addr;
			end
			dma_chan_pkg::ST_WRITE: begin
				s_next.mem.req   = 1'b1;
				s_next.mem.write = 1'b1;
				s_next.mem.size  = s_next.ctrl.destination_word_size;
				s_next.mem.addr  = dst_addr;
			end
			default: begin
			end
		endcase

		s_next.tc_irq = s_next.tc_sts && s_next.mask[dma_chan_pkg::MASK_TC];
		s_next.nl_irq = s_next.null_sts && s_next.mask[dma_chan_pkg::MASK_NULL];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg        <= '0;
			s_reg.fsm    <= dma_chan_pkg::ST_IDLE;
			s_reg.ctrl   <= dma_chan_pkg::ctrl_t'(dma_chan_pkg::CTRL_RST);
			s_reg.stride <= dma_chan_pkg::stride_t'(dma_chan_pkg::STRIDE_RST);
			s_reg.mask   <= dma_chan_pkg::MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata          = s_reg.prdata;
	assign pready          = s_reg.pready;
	assign pslverr         = s_reg.pslverr;
	assign mem_req         = s_reg.mem;
	assign hash_valid      = s_reg.hv;
	assign hash_data       = s_reg.hd;
	assign hash_fifo_level = s_reg.fcnt;
	assign tc_irq          = s_reg.tc_irq;
	assign null_link_irq   = s_reg.nl_irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_word_written;
		s_reg.fsm == dma_chan_pkg::ST_WRITE && mem_ack && s_reg.ctrl.hash_feed_enable;
	endsequence
	property p_hash_after_write;
		s_word_written |=> s_reg.fsm == dma_chan_pkg::ST_HASH ##[0:8] push;
	endproperty
	a_hash_after_write: assert property (p_hash_after_write) else $error("hash feed lost");

	property p_level_read;
		apb_setup && paddr == dma_chan_pkg::OFS_STATUS |=>
			s_reg.prdata[dma_chan_pkg::STS_FIFO_LVL +: 3] == $past(s_reg.fcnt);
	endproperty
	a_level_read: assert property (p_level_read) else $error("fifo level read wrong");

	property p_drain_idle;
		s_reg.fsm == dma_chan_pkg::ST_IDLE && s_reg.fcnt != 3'h0 && !s_reg.hv |=> s_reg.hv;
	endproperty
	a_drain_idle: assert property (p_drain_idle) else $error("fifo not drained");

	sequence s_term_dbuf;
		s_reg.fsm == dma_chan_pkg::ST_TERM && !s_reg.ctrl.chain_enable &&
			s_reg.ctrl.double_buffer_enable && !apb_wr;
	endsequence
	property p_reload;
		s_term_dbuf |=> s_reg.pri[2:0] == $past(s_reg.sec[2:0]) &&
			s_reg.fsm == dma_chan_pkg::ST_LOAD;
	endproperty
	a_reload: assert property (p_reload) else $error("secondary not copied");

	property p_reenable;
		s_term_dbuf |=> s_reg.ctrl.channel_enable && !s_reg.ctrl.double_buffer_enable;
	endproperty
	a_reenable: assert property (p_reenable) else $error("reload enable bits wrong");

	property p_stop;
		s_reg.fsm == dma_chan_pkg::ST_TERM && !s_reg.ctrl.chain_enable &&
			!s_reg.ctrl.double_buffer_enable && !apb_wr |=>
			!s_reg.ctrl.channel_enable && s_reg.fsm == dma_chan_pkg::ST_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("channel not disabled");

	property p_link_start;
		s_reg.fsm == dma_chan_pkg::ST_IDLE && s_reg.ctrl.channel_enable &&
			s_reg.ctrl.chain_enable |=> s_reg.fsm == dma_chan_pkg::ST_FETCH && s_reg.fidx == 2'h0;
	endproperty
	a_link_start: assert property (p_link_start) else $error("no descriptor fetch");

	property p_fetch_addr;
		s_reg.fsm == dma_chan_pkg::ST_FETCH |-> s_reg.mem.req && !s_reg.mem.write &&
			s_reg.mem.addr == s_reg.pri[dma_chan_pkg::DESC_LINK] + {28'h0, s_reg.fidx, 2'h0};
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

	property p_chain_end;
		s_reg.fsm == dma_chan_pkg::ST_TERM && s_reg.ctrl.chain_enable && !apb_wr &&
			s_reg.pri[dma_chan_pkg::DESC_LINK] == dma_chan_pkg::NULL_LINK |=>
			!s_reg.ctrl.double_buffer_enable && !s_reg.ctrl.channel_enable && s_reg.tc_sts;
	endproperty
	a_chain_end: assert property (p_chain_end) else $error("chain not ended");

	property p_null_seen;
		s_reg.fsm == dma_chan_pkg::ST_FETCH && mem_ack && s_reg.fidx == dma_chan_pkg::DESC_LAST &&
			mem_rdata == dma_chan_pkg::NULL_LINK |=> s_reg.null_sts ##1 s_reg.nl_irq == s_reg.mask[1];
	endproperty
	a_null_seen: assert property (p_null_seen) else $error("null link not flagged");

	property p_go;
		s_reg.fsm == dma_chan_pkg::ST_WAIT && s_reg.ctrl.channel_enable &&
			(s_reg.ctrl.software_transfer_enable || dreq) |=> s_reg.fsm == dma_chan_pkg::ST_READ;
	endproperty
	a_go: assert property (p_go) else $error("transfer not started");

endmodule

//--- hdl/dma_chan_pkg.sv
package dma_chan_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STRIDE = 8'h04;
	localparam logic [7:0] OFS_PRI    = 8'h08;
	localparam logic [7:0] OFS_SEC    = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_MASK   = 8'h2c;
	localparam logic [7:0] OFS_IRQ    = 8'h30;

	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] STRIDE_RST = 32'h0000_0000;
	localparam logic [1:0]  MASK_RST   = 2'h0;

	// status, mask and irq-status bit positions
	localparam int STS_TC       = 0;
	localparam int STS_NULL     = 1;
	localparam int STS_FIFO_NE  = 2;
	localparam int STS_FIFO_LVL = 3;
	localparam int STS_BUSY     = 6;
	localparam int MASK_TC      = 0;
	localparam int MASK_NULL    = 1;

	// ----------------------------------------------------------------
	// descriptor layout: word index i sits at link address + 4*i
	// ----------------------------------------------------------------
	localparam int DESC_SRC  = 0;
	localparam int DESC_DST  = 1;
	localparam int DESC_LEN  = 2;
	localparam int DESC_LINK = 3;
	localparam logic [1:0]  DESC_LAST       = 2'h3;
	localparam logic [31:0] DESC_WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] NULL_LINK       = 32'h0000_0000;

	localparam int         FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_FULL  = 3'h4;

	typedef logic [3:0][31:0] desc_t;

	typedef struct packed {
		logic [16:0] rsvd;
		logic        destination_stride_enable;
		logic        source_stride_enable;
		logic [1:0]  destination_word_size;
		logic [1:0]  source_word_size;
		logic        link_int_every;
		logic        destination_hold_address;
		logic        source_hold_address;
		logic        null_destination_select;
		logic        hash_feed_enable;
		logic        software_transfer_enable;
		logic        chain_enable;
		logic        double_buffer_enable;
		logic        channel_enable;
	} ctrl_t;

	typedef struct packed {
		logic [23:0] rsvd;
		logic [3:0]  stride_steps_per_set;
		logic [3:0]  stride_step_multiple;
	} stride_t;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;

	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_FETCH = 9'h002,
		ST_LOAD  = 9'h004,
		ST_WAIT  = 9'h008,
		ST_READ  = 9'h010,
		ST_WRITE = 9'h020,
		ST_HASH  = 9'h040,
		ST_STEP  = 9'h080,
		ST_TERM  = 9'h100
	} state_t;

	function automatic logic [31:0] size_bytes(input logic [1:0] sz);
		return 32'h0000_0001 << sz;
	endfunction

	function automatic logic [31:0] fetch_addr(input logic [31:0] link, input logic [1:0] idx);
		return link + DESC_WORD_BYTES * {30'h0, idx};
	endfunction

endpackage

//--- hdl/dma_addr_gen.sv
`timescale 1ns/1ps

module dma_addr_gen (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        load,
	input  wire logic [31:0] base,
	input  wire logic        advance,
	input  wire logic        hold,
	input  wire logic        stride_en,
	input  wire logic [1:0]  size,
	input  wire logic [3:0]  step_mult,
	input  wire logic [3:0]  steps,
	output logic      [31:0] addr
);

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] set_start;
		logic [3:0]  idx;
	} ag_t;

	ag_t         s_reg;
	ag_t         s_next;
	logic [31:0] step;

	always_comb begin
		s_next = s_reg;
		step   = dma_chan_pkg::size_bytes(size);
		if (load) begin
			s_next.addr      = base;
			s_next.set_start = base;
			s_next.idx       = 4'h0;
		end else if (advance && !hold) begin
			if (!stride_en) begin
				s_next.addr = s_reg.addr + step;
			end else if (s_reg.idx == steps) begin
				// new set: previous set start plus one word
				s_next.set_start = s_reg.set_start + step;
				s_next.addr      = s_reg.set_start + step;
				s_next.idx       = 4'h0;
			end else begin
				s_next.addr = s_reg.addr + step * ({28'h0, step_mult} + 32'h1);
				s_next.idx  = s_reg.idx + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign addr = s_reg.addr;

	property p_stride_step;
		@(posedge pclk) disable iff (!presetn)
		!load && advance && !hold && stride_en && s_reg.idx != steps |=>
			addr == $past(s_reg.addr) + $past(step) * ({28'h0, $past(step_mult)} + 32'h1);
	endproperty
	a_stride_step: assert property (p_stride_step) else $error("stride step wrong");

	property p_stride_wrap;
		@(posedge pclk) disable iff (!presetn)
		!load && advance && !hold && stride_en && s_reg.idx == steps |=>
			addr == $past(s_reg.set_start) + $past(step) && s_reg.idx == 4'h0;
	endproperty
	a_stride_wrap: assert property (p_stride_wrap) else $error("stride set wrap wrong");

endmodule

//--- bench/mem_model.sv
`timescale 1ns/1ps

module mem_model (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire dma_chan_pkg::mem_req_t mem_req,
	input  wire logic                   slow,
	output logic                        mem_ack,
	output logic      [31:0]            mem_rdata
);
	logic [31:0] mem [64];
	int          wr_count;
	logic        wait_reg;

	initial for (int i = 0; i < 64; i++) mem[i] = 32'hc0de_0000 + i;

	// one outstanding request, answered at once or after one wait cycle
	// plain always: the bench preloads descriptor words into mem
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_reg <= 1'b0;
			wr_count <= 0;
			mem_rdata <= 32'h0;
		end else if (mem_req.req && !mem_ack && (wait_reg || !slow)) begin
			mem_ack <= 1'b1;
			wait_reg <= 1'b0;
			mem_rdata <= mem[mem_req.addr[7:2]];
			if (mem_req.write) begin
				mem[mem_req.addr[7:2]] <= mem_req.wdata;
				wr_count <= wr_count + 1;
			end
		end else begin
			mem_ack <= 1'b0;
			wait_reg <= mem_req.req && !mem_ack;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, dreq, slow, ev;
	logic hash_valid, hash_ready, tc_irq, null_link_irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_rdata, hash_data, rv;
	logic [2:0] hash_fifo_level;
	dma_chan_pkg::mem_req_t mem_req;
	int err_count, compares;

	dma_chan_seq dma_chan_seq_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.dreq(dreq), .hash_valid(hash_valid), .hash_data(hash_data), .hash_ready(hash_ready),
		.hash_fifo_level(hash_fifo_level), .tc_irq(tc_irq), .null_link_irq(null_link_irq));
	mem_model mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .slow(slow),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task stop_test;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(0, 1, "apb timeout");
			stop_test;
		end
		rv = prdata;
		ev = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task setp(input logic [7:0] b, input logic [31:0] s, input logic [31:0] d, input logic [31:0] l);
		apb(1, b, s);
		apb(1, b + 8'h04, d);
		apb(1, b + 8'h08, l);
	endtask

	// wait for n more memory writes, bounded
	task run(input int n);
		int k;
		int w0;
		w0 = mem_model_inst.wr_count;
		for (k = 0; k < 500 && mem_model_inst.wr_count - w0 < n; k++) @(posedge pclk);
		if (k >= 500) begin
			chk(0, 1, "transfer timeout");
			stop_test;
		end
		repeat (20) @(posedge pclk);
	endtask

	task t_regs;
		apb(0, dma_chan_pkg::OFS_CTRL, 0);
		chk(rv, dma_chan_pkg::CTRL_RST, "ctrl reset");
		apb(1, 8'h40, 32'h1);
		chk(32'(ev), 1, "unmapped access");
	endtask

	task t_hash;
		int k;
		hash_ready <= 1'b0;
		setp(dma_chan_pkg::OFS_PRI, 32'h10, 32'h40, 32'h4);
		apb(1, dma_chan_pkg::OFS_MASK, 32'h3);
		apb(1, dma_chan_pkg::OFS_CTRL, 32'h1419);
		run(1);
		chk(mem_model_inst.mem[16], 32'hc0de_0004, "normal dest");
		chk({hash_valid, hash_data}, {1'b1, 32'hc0de_0004}, "hash word");
		chk(32'(tc_irq), 1, "tc irq");
		apb(0, dma_chan_pkg::OFS_CTRL, 0);
		chk(rv[0], 0, "channel off");
		hash_ready <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(32'(hash_valid), 0, "hash drained");
		// hash-only copy: second word waits in the fifo behind a stalled output
		hash_ready <= 1'b0;
		setp(dma_chan_pkg::OFS_PRI, 32'h24, 32'h44, 32'h8);
		apb(1, dma_chan_pkg::OFS_CTRL, 32'h1439);
		for (k = 0; k < 500 && hash_valid !== 1'b1; k++) @(posedge pclk);
		if (k >= 500) begin
			chk(0, 1, "hash timeout");
			stop_test;
		end
		repeat (20) @(posedge pclk);
		chk({hash_valid, hash_data}, {1'b1, 32'hc0de_0009}, "hash only word");
		chk(mem_model_inst.mem[17], 32'hc0de_0011, "null destination");
		chk(32'(hash_fifo_level), 1, "fifo level");
		apb(0, dma_chan_pkg::OFS_STATUS, 0);
		chk(rv[6:2], 5'h03, "fifo pending after stop");
		hash_ready <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(32'(hash_valid), 0, "second word drained");
	endtask

	task t_dbuf;
		apb(1, dma_chan_pkg::OFS_STATUS, 32'h3);
		setp(dma_chan_pkg::OFS_PRI, 32'h14, 32'h48, 32'h4);
		setp(dma_chan_pkg::OFS_SEC, 32'h18, 32'h4c, 32'h4);
		apb(1, dma_chan_pkg::OFS_CTRL, 32'h140b);
		run(2);
		chk(mem_model_inst.mem[18], 32'hc0de_0005, "first buffer");
		chk(mem_model_inst.mem[19], 32'hc0de_0006, "reloaded buffer");
		apb(0, dma_chan_pkg::OFS_CTRL, 0);
		chk(rv[1:0], 0, "db and enable clear");
	endtask

	task t_link;
		slow <= 1'b1;
		dreq <= 1'b1;
		apb(1, dma_chan_pkg::OFS_STATUS, 32'h3);
		mem_model_inst.mem[32] = 32'h1c;
		mem_model_inst.mem[33] = 32'h50;
		mem_model_inst.mem[34] = 32'h4;
		mem_model_inst.mem[35] = 32'h0;
		apb(1, dma_chan_pkg::OFS_PRI + 8'h0c, 32'h80);
		apb(1, dma_chan_pkg::OFS_CTRL, 32'h1407);
		run(1);
		chk(mem_model_inst.mem[20], 32'hc0de_0007, "linked copy");
		apb(0, dma_chan_pkg::OFS_STATUS, 0);
		chk({rv[1], null_link_irq}, 2'b11, "null link");
		apb(0, dma_chan_pkg::OFS_CTRL, 0);
		chk(rv[1:0], 0, "chain end");
		apb(1, dma_chan_pkg::OFS_CTRL, 0);
		slow <= 1'b0;
		dreq <= 1'b0;
	endtask

	task t_stride;
		setp(dma_chan_pkg::OFS_PRI, 32'h20, 32'h60, 32'hc);
		apb(1, dma_chan_pkg::OFS_STRIDE, 32'h13);
		apb(1, dma_chan_pkg::OFS_CTRL, 32'h5409);
		run(3);
		chk(mem_model_inst.mem[24], 32'hc0de_0008, "stride first");
		chk(mem_model_inst.mem[28], 32'hc0de_0009, "stride step");
		chk(mem_model_inst.mem[25], 32'hc0de_000a, "next set");
	endtask

	initial begin
		{presetn, psel, penable, pwrite, dreq, slow, hash_ready} = 7'b0000001;
		paddr = 8'h0;
		pwdata = 32'h0;
		err_count = 0;
		compares = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_hash;
		t_dbuf;
		t_link;
		t_stride;
		stop_test;
	end
endmodule
